// [design/mcuirq_edge.sv]
`timescale 1ns/1ps
module mcuirq_edge (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic pin,
  input  wire logic rising,
  output logic      edge_seen
);
  logic sync_a;
  logic sync_b;
  logic last;

  // ----------------------------------------
  // pin synchroniser and edge detector
  // ----------------------------------------
  // the chain keeps running through reset, so a pin idling high
  // shows no false edge once reset lets go
  always_ff @(posedge sys_clk) begin
    sync_a <= pin;
    sync_b <= sync_a;
    last   <= sync_b;
  end

  // an edge of either kind is judged on synchronised levels only
  assign edge_seen = !rst && (rising ? (sync_b & ~last) : (~sync_b & last));

endmodule : mcuirq_edge

// [design/mcuirq_top.sv]
`timescale 1ns/1ps
module mcuirq_top #(
  parameter int PIN_COUNT = 8,
  parameter int PERIPH_W  = 8
) (
  input  wire logic                                  sys_clk,
  input  wire logic                                  rst,
  input  wire logic [3:0]                            reg_addr,
  input  wire logic [7:0]                            reg_wdata,
  input  wire logic                                  reg_wr,
  input  wire logic                                  reg_rd,
  output logic      [7:0]                            reg_rdata,
  input  wire logic [PIN_COUNT-1:0]                  ext_pins,
  input  wire logic                                  timer_zero_ovf_event,
  input  wire logic                                  pin_change_event,
  input  wire logic [PERIPH_W-1:0]                   periph_event,
  input  wire logic                                  periph_wake_capable,
  input  wire logic                                  first_quarter_phase,
  input  wire logic                                  core_sleep,
  input  wire logic                                  return_from_interrupt,
  input  wire mcuirq_pkg::mcuirq_ctx_t               core_ctx,
  output logic                                       irq_enter,
  output logic                                       flush_prefetch,
  output logic                                       push_pc,
  output logic [14:0]                                vector_addr,
  output logic                                       pop_pc,
  output logic                                       ctx_restore,
  output mcuirq_pkg::mcuirq_ctx_t                    restore_ctx,
  output logic                                       wake,
  output logic                                       irq_pending,
  output logic                                       irq
);
  localparam int PIN_SEL_W_L = mcuirq_pkg::PIN_SEL_W;

  logic [7:0]                 control;
  logic [7:0]                 enable0;
  logic [7:0]                 flags0;
  logic [PIN_SEL_W_L-1:0]     pin_select;
  logic [PERIPH_W-1:0]        periph_en;
  logic [PERIPH_W-1:0]        periph_fl;
  mcuirq_pkg::mcuirq_ctx_t    shadow;
  mcuirq_pkg::mcuirq_state_t  state;
  logic                       ext_edge;
  logic                       sel_pin;
  logic                       core_req;
  logic                       take;
  logic                       wake_req;
  logic [7:0]                 ctl_rd;
  logic [PIN_COUNT-1:0]       pin_meta;
  logic [PIN_COUNT-1:0]       pin_sync;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] k);
    hit = reg_wr && (a == k);
  endfunction : hit

  // ----------------------------------------
  // external pin select and edge detect
  // ----------------------------------------
  // pins are asynchronous: the select mux only ever sees registered levels;
  // costs two extra cycles of latency, switching the select can fake an edge
  always_ff @(posedge sys_clk) begin
    pin_meta <= ext_pins;
    pin_sync <= pin_meta;
  end

  assign sel_pin = pin_sync[pin_select];

  mcuirq_edge i_mcuirq_edge (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .pin       (sel_pin),
    .rising    (control[mcuirq_pkg::BIT_EDGE]),
    .edge_seen (ext_edge)
  );

  // ----------------------------------------
  // request forming
  // ----------------------------------------
  always_comb begin
    core_req = (flags0[mcuirq_pkg::BIT_EXT] & enable0[mcuirq_pkg::BIT_EXT])
             | (flags0[mcuirq_pkg::BIT_TMR0] & enable0[mcuirq_pkg::BIT_TMR0])
             | (flags0[mcuirq_pkg::BIT_PIN_CHANGE] & enable0[mcuirq_pkg::BIT_PIN_CHANGE])
             | (control[mcuirq_pkg::BIT_GROUP_EN] & |(periph_fl & periph_en));
  end

  // level pending stays high while global is clear, so service resumes later
  assign irq_pending = core_req;
  assign irq         = core_req & control[mcuirq_pkg::BIT_GLOBAL_EN];
  // sampled only in the first quarter and only while running
  assign take = irq && first_quarter_phase && (state == mcuirq_pkg::MCUIRQ_RUN);
  // wake needs the source enable only, not the global one
  assign wake_req = core_req
                  | (periph_wake_capable & |(periph_fl & periph_en));

  // ----------------------------------------
  // sleep and wake sequencing
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= mcuirq_pkg::MCUIRQ_RUN;
    end else begin
      case (state)
        mcuirq_pkg::MCUIRQ_RUN: begin
          if (core_sleep && !take) begin
            state <= mcuirq_pkg::MCUIRQ_SLEEP;
          end
        end
        mcuirq_pkg::MCUIRQ_SLEEP: begin
          if (wake_req) begin
            state <= mcuirq_pkg::MCUIRQ_WAKE_STEP;
          end
        end
        mcuirq_pkg::MCUIRQ_WAKE_STEP: begin
          // one instruction after sleep runs before any vectoring
          if (first_quarter_phase) begin
            state <= mcuirq_pkg::MCUIRQ_RUN;
          end
        end
        default: state <= mcuirq_pkg::MCUIRQ_RUN;
      endcase
    end
  end

  assign wake = (state == mcuirq_pkg::MCUIRQ_SLEEP) && wake_req;

  // ----------------------------------------
  // core redirect strobes
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_enter      <= 1'b0;
      flush_prefetch <= 1'b0;
      push_pc        <= 1'b0;
      pop_pc         <= 1'b0;
      ctx_restore    <= 1'b0;
      vector_addr    <= mcuirq_pkg::IRQ_VECTOR;
    end else begin
      irq_enter      <= take;
      flush_prefetch <= take;
      push_pc        <= take;
      pop_pc         <= return_from_interrupt && !take;
      ctx_restore    <= return_from_interrupt && !take;
      vector_addr    <= mcuirq_pkg::IRQ_VECTOR;
    end
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      control <= mcuirq_pkg::CONTROL_RESET;
    end else begin
      if (hit(reg_addr, mcuirq_pkg::ADDR_CONTROL)) begin
        control[mcuirq_pkg::BIT_GLOBAL_EN] <= reg_wdata[mcuirq_pkg::BIT_GLOBAL_EN];
        control[mcuirq_pkg::BIT_GROUP_EN]  <= reg_wdata[mcuirq_pkg::BIT_GROUP_EN];
        control[mcuirq_pkg::BIT_EDGE]      <= reg_wdata[mcuirq_pkg::BIT_EDGE];
      end
      // hardware wins over a same-cycle software write
      if (take) begin
        control[mcuirq_pkg::BIT_GLOBAL_EN] <= 1'b0;
      end else if (return_from_interrupt) begin
        control[mcuirq_pkg::BIT_GLOBAL_EN] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // enable registers and pin select
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      enable0    <= mcuirq_pkg::ZERO8;
      periph_en  <= '0;
      pin_select <= '0;
    end else begin
      if (hit(reg_addr, mcuirq_pkg::ADDR_ENABLE0)) begin
        enable0 <= reg_wdata & mcuirq_pkg::ENABLE0_MASK;
      end
      if (hit(reg_addr, mcuirq_pkg::ADDR_PERIPH_EN)) begin
        periph_en <= reg_wdata[PERIPH_W-1:0];
      end
      if (hit(reg_addr, mcuirq_pkg::ADDR_PIN_SELECT)) begin
        pin_select <= reg_wdata[PIN_SEL_W_L-1:0];
      end
    end
  end

  // ----------------------------------------
  // event flags: sticky, write one to clear, set wins
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flags0    <= mcuirq_pkg::ZERO8;
      periph_fl <= '0;
    end else begin
      // clearing is left to the service routine; a stale flag re-enters
      flags0 <= ((flags0 & ~(hit(reg_addr, mcuirq_pkg::ADDR_FLAGS0) ? reg_wdata : 8'h00))
                | {2'b00, timer_zero_ovf_event, pin_change_event, 3'b000, ext_edge})
                & mcuirq_pkg::ENABLE0_MASK;
      periph_fl <= (periph_fl
                    & ~(hit(reg_addr, mcuirq_pkg::ADDR_PERIPH_FL) ? reg_wdata[PERIPH_W-1:0]
                                                                 : '0))
                   | periph_event;
    end
  end

  // ----------------------------------------
  // shadow context
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shadow <= '0;
    end else if (take) begin
      shadow        <= core_ctx;
      shadow.status <= core_ctx.status & mcuirq_pkg::STATUS_SAVE_MASK;
    end else if (reg_wr) begin
      // software edits take effect at return
      case (reg_addr)
        mcuirq_pkg::ADDR_SH_W:      shadow.w      <= reg_wdata;
        mcuirq_pkg::ADDR_SH_STATUS: shadow.status <= reg_wdata & mcuirq_pkg::STATUS_SAVE_MASK;
        mcuirq_pkg::ADDR_SH_BANK:    shadow.bank_select <= reg_wdata;
        mcuirq_pkg::ADDR_SH_FSR0L:   shadow.fsr0l       <= reg_wdata;
        mcuirq_pkg::ADDR_SH_FSR0H:   shadow.fsr0h       <= reg_wdata;
        mcuirq_pkg::ADDR_SH_FSR1L:   shadow.fsr1l       <= reg_wdata;
        mcuirq_pkg::ADDR_SH_FSR1H:   shadow.fsr1h       <= reg_wdata;
        mcuirq_pkg::ADDR_SH_PC_HIGH: shadow.pc_high     <= reg_wdata;
        default: shadow <= shadow;
      endcase
    end
  end

  // status timeout and powerdown bits stay with the core, not the shadow
  assign restore_ctx = shadow;

  // ----------------------------------------
  // read port, data one cycle after strobe
  // ----------------------------------------
  assign ctl_rd = {control[mcuirq_pkg::BIT_GLOBAL_EN], control[mcuirq_pkg::BIT_GROUP_EN],
                   5'b00000, control[mcuirq_pkg::BIT_EDGE]};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= mcuirq_pkg::ZERO8;
    end else if (reg_rd) begin
      case (reg_addr)
        mcuirq_pkg::ADDR_CONTROL:    reg_rdata <= ctl_rd;
        mcuirq_pkg::ADDR_ENABLE0:    reg_rdata <= enable0;
        mcuirq_pkg::ADDR_FLAGS0:     reg_rdata <= flags0;
        mcuirq_pkg::ADDR_PIN_SELECT: reg_rdata <= 8'(pin_select);
        mcuirq_pkg::ADDR_SH_W:       reg_rdata <= shadow.w;
        mcuirq_pkg::ADDR_SH_STATUS:  reg_rdata <= shadow.status;
        mcuirq_pkg::ADDR_SH_BANK:    reg_rdata <= shadow.bank_select;
        mcuirq_pkg::ADDR_SH_FSR0L:   reg_rdata <= shadow.fsr0l;
        mcuirq_pkg::ADDR_SH_FSR0H:   reg_rdata <= shadow.fsr0h;
        mcuirq_pkg::ADDR_SH_FSR1L:   reg_rdata <= shadow.fsr1l;
        mcuirq_pkg::ADDR_SH_FSR1H:   reg_rdata <= shadow.fsr1h;
        mcuirq_pkg::ADDR_SH_PC_HIGH: reg_rdata <= shadow.pc_high;
        mcuirq_pkg::ADDR_PERIPH_EN:  reg_rdata <= 8'(periph_en);
        mcuirq_pkg::ADDR_PERIPH_FL:  reg_rdata <= 8'(periph_fl);
        default:                     reg_rdata <= mcuirq_pkg::ZERO8;
      endcase
    end else begin
      reg_rdata <= mcuirq_pkg::ZERO8;
    end
  end

endmodule : mcuirq_top

// [inc/mcuirq_pkg.sv]
// What this block does
// - every reset clears all interrupt enables
// - flags set regardless of any enable
// - peripheral needs global, group, own enable
// - entry: flush, clear global, push, save, vector
// - pending event serviced once global set again
// - return pops, restores context, sets global
// - sample requests in first quarter phase
// - enabled clockless source may wake from sleep
// - after wake run next instruction, then vector
// - external pin edge chosen by edge select
// - valid edge sets external flag, gated redirect
// - entry copies working, status, bank, pointers, latch
// - return restores shadows; shadows software accessible
// - control bit 7 global, bits 5-1 zero
// - bit 6 group enable, bit 0 edge, reset one
// - enable zero bits 5, 4, 0 only
// - external pin chosen by pin select register
package mcuirq_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [3:0] ADDR_CONTROL    = 4'h0;
  localparam logic [3:0] ADDR_ENABLE0    = 4'h1;
  localparam logic [3:0] ADDR_FLAGS0     = 4'h2;
  localparam logic [3:0] ADDR_PIN_SELECT = 4'h3;
  localparam logic [3:0] ADDR_SH_W       = 4'h4;
  localparam logic [3:0] ADDR_SH_STATUS  = 4'h5;
  localparam logic [3:0] ADDR_SH_BANK    = 4'h6;
  localparam logic [3:0] ADDR_SH_FSR0L   = 4'h7;
  localparam logic [3:0] ADDR_SH_FSR0H   = 4'h8;
  localparam logic [3:0] ADDR_SH_FSR1L   = 4'h9;
  localparam logic [3:0] ADDR_SH_FSR1H   = 4'hA;
  localparam logic [3:0] ADDR_SH_PC_HIGH = 4'hB;
  localparam logic [3:0] ADDR_PERIPH_EN  = 4'hC;
  localparam logic [3:0] ADDR_PERIPH_FL  = 4'hD;

  // ----------------------------------------
  // fields
  // ----------------------------------------
  localparam int BIT_GLOBAL_EN  = 7;
  localparam int BIT_GROUP_EN   = 6;
  localparam int BIT_EDGE       = 0;
  localparam int BIT_TMR0       = 5;
  localparam int BIT_PIN_CHANGE = 4;
  localparam int BIT_EXT        = 0;
  localparam int BIT_TIMEOUT    = 4;
  localparam int BIT_POWERDOWN  = 3;
  localparam logic [7:0] ENABLE0_MASK = 8'h31;
  localparam logic [7:0] STATUS_SAVE_MASK = 8'hE7;
  localparam logic [7:0] CONTROL_RESET = 8'h01;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [14:0] IRQ_VECTOR = 15'h0004;
  localparam int PIN_SEL_W = 3;

  // ----------------------------------------
  // context carried between core and shadows
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] w;
    logic [7:0] status;
    logic [7:0] bank_select;
    logic [7:0] fsr0l;
    logic [7:0] fsr0h;
    logic [7:0] fsr1l;
    logic [7:0] fsr1h;
    logic [7:0] pc_high;
  } mcuirq_ctx_t;

  typedef enum logic [1:0] {
    MCUIRQ_RUN,
    MCUIRQ_SLEEP,
    MCUIRQ_WAKE_STEP
  } mcuirq_state_t;

endpackage : mcuirq_pkg

// [tb/mcuirq_core_model.sv]
`timescale 1ns/1ps
module mcuirq_core_model (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic irq_enter,
  input  wire logic pop_pc,
  input  wire logic ret_cmd,
  output logic      first_quarter_phase,
  output logic      return_from_interrupt,
  output logic      in_service
);
  logic [1:0] phase_cnt;

  // ----------------------------------------
  // four clocks to one instruction cycle
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) phase_cnt <= 2'h0;
    else phase_cnt <= phase_cnt + 2'h1;
  end
  assign first_quarter_phase = (phase_cnt == 2'h0) && !rst;

  // ----------------------------------------
  // return only from inside a service routine
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      in_service            <= 1'b0;
      return_from_interrupt <= 1'b0;
    end else begin
      return_from_interrupt <= ret_cmd && in_service;
      if (irq_enter) in_service <= 1'b1;
      else if (pop_pc) in_service <= 1'b0;
    end
  end
endmodule : mcuirq_core_model

// [tb/mcuirq_properties.sv]
`timescale 1ns/1ps
module mcuirq_props (
  input wire logic                     sys_clk,
  input wire logic                     rst,
  input wire logic                     first_quarter_phase,
  input wire logic                     return_from_interrupt,
  input wire logic                     irq_enter,
  input wire logic                     flush_prefetch,
  input wire logic                     push_pc,
  input wire logic [14:0]              vector_addr,
  input wire logic                     pop_pc,
  input wire logic                     ctx_restore,
  input wire mcuirq_pkg::mcuirq_ctx_t  restore_ctx,
  input wire logic                     wake,
  input wire logic                     irq_pending,
  input wire logic                     irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // entry and return
  // ----------------------------------------
  a_entry_cause: assert property (
    irq_enter |-> $past(irq && first_quarter_phase)) else $error("entry without request");
  a_entry_set: assert property (
    irq_enter |-> flush_prefetch && push_pc && !irq) else $error("entry set incomplete");
  a_entry_once: assert property (
    irq_enter |=> !irq_enter) else $error("entry pulse too long");
  a_return_seq: assert property (
    return_from_interrupt && !(irq && first_quarter_phase) |=> pop_pc && ctx_restore)
    else $error("return not answered");
  a_pop_cause: assert property (
    pop_pc |-> $past(return_from_interrupt)) else $error("pop without return");
  a_global_back: assert property (
    pop_pc |-> irq == irq_pending) else $error("global not set on return");
  a_irq_gated: assert property (
    irq |-> irq_pending) else $error("request without enabled flag");
  a_vector_fixed: assert property (
    vector_addr == 15'h0004) else $error("vector wrong");
  a_shadow_mask: assert property (
    ctx_restore |-> restore_ctx.status[4:3] == 2'b00) else $error("status bits restored");
  a_reset_quiet: assert property (
    $past(rst) |-> !irq && !irq_enter) else $error("request right after reset");

  c_entry: cover property (irq_enter);
  c_return: cover property (pop_pc);
  c_wake: cover property (wake);
endmodule : mcuirq_props

bind mcuirq_top mcuirq_props i_mcuirq_props (
  .sys_clk(sys_clk), .rst(rst), .first_quarter_phase(first_quarter_phase),
  .return_from_interrupt(return_from_interrupt), .irq_enter(irq_enter),
  .flush_prefetch(flush_prefetch), .push_pc(push_pc), .vector_addr(vector_addr),
  .pop_pc(pop_pc), .ctx_restore(ctx_restore), .restore_ctx(restore_ctx),
  .wake(wake), .irq_pending(irq_pending), .irq(irq));

// [tb/tb_mcu_interrupt_logic.sv]
`timescale 1ns/1ps
module tb_mcu_interrupt_logic;
  logic                    sys_clk, rst, reg_wr, reg_rd, tmr_ev, chg_ev, sleep_req, ret_cmd;
  logic [3:0]              reg_addr;
  logic [7:0]              reg_wdata, reg_rdata, ext_pins, periph_event;
  logic                    fqp, rfi, in_service, irq_enter, flush_prefetch, push_pc;
  logic                    pop_pc, ctx_restore, wake, irq_pending, irq, wake_cap;
  logic [14:0]             vector_addr;
  mcuirq_pkg::mcuirq_ctx_t core_ctx, restore_ctx;
  int                      errors, total_checks;

  mcuirq_top i_mcuirq_top (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_pins(ext_pins), .timer_zero_ovf_event(tmr_ev), .pin_change_event(chg_ev),
    .periph_event(periph_event), .periph_wake_capable(wake_cap), .first_quarter_phase(fqp),
    .core_sleep(sleep_req), .return_from_interrupt(rfi), .core_ctx(core_ctx),
    .irq_enter(irq_enter), .flush_prefetch(flush_prefetch), .push_pc(push_pc),
    .vector_addr(vector_addr), .pop_pc(pop_pc), .ctx_restore(ctx_restore),
    .restore_ctx(restore_ctx), .wake(wake), .irq_pending(irq_pending), .irq(irq));
  mcuirq_core_model i_mcuirq_core_model (.sys_clk(sys_clk), .rst(rst), .irq_enter(irq_enter),
    .pop_pc(pop_pc), .ret_cmd(ret_cmd), .first_quarter_phase(fqp),
    .return_from_interrupt(rfi), .in_service(in_service));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic print_verdict;
    if (errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; end
    @(posedge sys_clk) reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge sys_clk) begin reg_rd <= 1'b1; reg_addr <= a; end
    @(posedge sys_clk) reg_rd <= 1'b0;
    #1 chk(nm, {8'h00, reg_rdata}, {8'h00, e});
  endtask : rd
  // wake is only a short level, so every wait polls each cycle
  task automatic wait_hi(input int sel);
    for (int n = 0; n < 20; n++) begin
      @(posedge sys_clk);
      #1;
      if ((sel == 0 && irq_enter === 1'b1) || (sel == 1 && ctx_restore === 1'b1)
          || (sel == 2 && wake === 1'b1)) return;
    end
    errors++;
    $display("ERROR wait %0d expected 1 seen 0", sel);
    print_verdict();
  endtask : wait_hi
  task automatic do_return;
    @(posedge sys_clk) ret_cmd <= 1'b1;
    @(posedge sys_clk) ret_cmd <= 1'b0;
    wait_hi(1);
  endtask : do_return

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    {rst, reg_wr, reg_rd, tmr_ev, chg_ev, sleep_req, ret_cmd} = 7'h40;
    {reg_addr, reg_wdata, ext_pins, periph_event} = 28'h0;
    wake_cap = 1'b1;
    core_ctx = 64'h11FF_2233_4455_6677;
    errors = 0;
    total_checks = 0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rd(mcuirq_pkg::ADDR_CONTROL, 8'h01, "control");
    rd(mcuirq_pkg::ADDR_ENABLE0, 8'h00, "enable0");
    wr(mcuirq_pkg::ADDR_CONTROL, 8'hFF);
    rd(mcuirq_pkg::ADDR_CONTROL, 8'hC1, "control");
    wr(mcuirq_pkg::ADDR_CONTROL, 8'h01);
    wr(mcuirq_pkg::ADDR_ENABLE0, 8'hFF);
    rd(mcuirq_pkg::ADDR_ENABLE0, 8'h31, "enable0");
    rd(4'hE, 8'h00, "unmapped");
    wr(mcuirq_pkg::ADDR_ENABLE0, 8'h00);
    @(posedge sys_clk) begin tmr_ev <= 1'b1; chg_ev <= 1'b1; periph_event <= 8'h01; end
    @(posedge sys_clk) begin tmr_ev <= 1'b0; chg_ev <= 1'b0; periph_event <= 8'h00; end
    rd(mcuirq_pkg::ADDR_FLAGS0, 8'h30, "flags0");
    rd(mcuirq_pkg::ADDR_PERIPH_FL, 8'h01, "periph flags");
    wr(mcuirq_pkg::ADDR_FLAGS0, 8'h30);
    rd(mcuirq_pkg::ADDR_FLAGS0, 8'h00, "flags0");
    wr(mcuirq_pkg::ADDR_PERIPH_EN, 8'h01);
    chk("pending", irq_pending, 1'b0);
    wr(mcuirq_pkg::ADDR_CONTROL, 8'h41);
    chk("pending", irq_pending, 1'b1);
    chk("irq", irq, 1'b0);
    wr(mcuirq_pkg::ADDR_CONTROL, 8'hC1);
    wait_hi(0);
    chk("flush", flush_prefetch, 1'b1);
    chk("push", push_pc, 1'b1);
    chk("vector", vector_addr, 15'h0004);
    @(posedge sys_clk) core_ctx <= 64'h0;
    rd(mcuirq_pkg::ADDR_CONTROL, 8'h41, "control");
    rd(mcuirq_pkg::ADDR_SH_STATUS, 8'hE7, "shadow status");
    rd(mcuirq_pkg::ADDR_SH_PC_HIGH, 8'h77, "shadow latch");
    wr(mcuirq_pkg::ADDR_SH_W, 8'h5A);
    wr(mcuirq_pkg::ADDR_PERIPH_FL, 8'h01);
    do_return();
    chk("pop", pop_pc, 1'b1);
    chk("restore w", restore_ctx.w, 8'h5A);
    chk("restore status", restore_ctx.status, 8'hE7);
    rd(mcuirq_pkg::ADDR_CONTROL, 8'hC1, "control");
    chk("irq", irq, 1'b0);
    wr(mcuirq_pkg::ADDR_CONTROL, 8'h01);
    wr(mcuirq_pkg::ADDR_PIN_SELECT, 8'h03);
    wr(mcuirq_pkg::ADDR_ENABLE0, 8'h01);
    @(posedge sys_clk) ext_pins <= 8'h04;
    repeat (4) @(posedge sys_clk);
    rd(mcuirq_pkg::ADDR_FLAGS0, 8'h00, "other pin");
    @(posedge sys_clk) ext_pins <= 8'h0C;
    repeat (4) @(posedge sys_clk);
    rd(mcuirq_pkg::ADDR_FLAGS0, 8'h01, "ext flag");
    chk("pending", irq_pending, 1'b1);
    chk("irq", irq, 1'b0);
    wr(mcuirq_pkg::ADDR_FLAGS0, 8'h01);
    @(posedge sys_clk) ext_pins <= 8'h04;
    repeat (4) @(posedge sys_clk);
    rd(mcuirq_pkg::ADDR_FLAGS0, 8'h00, "falling");
    wr(mcuirq_pkg::ADDR_CONTROL, 8'h81);
    @(posedge sys_clk) sleep_req <= 1'b1;
    @(posedge sys_clk) sleep_req <= 1'b0;
    @(posedge sys_clk) ext_pins <= 8'h0C;
    wait_hi(2);
    chk("entry at wake", irq_enter, 1'b0);
    wait_hi(0);
    wr(mcuirq_pkg::ADDR_FLAGS0, 8'h01);
    do_return();
    // group enable is off: only a clockless peripheral may wake the core
    @(posedge sys_clk) begin wake_cap <= 1'b0; sleep_req <= 1'b1; periph_event <= 8'h01; end
    @(posedge sys_clk) begin sleep_req <= 1'b0; periph_event <= 8'h00; end
    repeat (2) @(posedge sys_clk);
    #1 chk("wake not capable", wake, 1'b0);
    @(posedge sys_clk) wake_cap <= 1'b1;
    #1 chk("wake capable", wake, 1'b1);
    wr(mcuirq_pkg::ADDR_PERIPH_FL, 8'h01);
    wr(mcuirq_pkg::ADDR_ENABLE0, 8'h31);
    @(posedge sys_clk) rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd(mcuirq_pkg::ADDR_CONTROL, 8'h01, "control");
    rd(mcuirq_pkg::ADDR_ENABLE0, 8'h00, "enable0");
    print_verdict();
  end
endmodule : tb_mcu_interrupt_logic
